// >>> common/cpp_pkg.sv
// cpp_pkg: shared constants for the colour pixel post-processing stage.
// assumes a 32-bit classic Wishbone register bus and 10-bit pixel components.
package cpp_pkg;

	// pixel and coefficient formats
	localparam int PIX_W   = 10;
	localparam int COEF_W  = 12;
	localparam int COEF_FB = 10;
	localparam logic [9:0] PIX_MAX = 10'h3FF;
	localparam logic signed [11:0] COEF_ONE     = 12'sh400;
	localparam logic signed [11:0] COEF_NEG_ONE = 12'shC00;
	localparam logic signed [11:0] COEF_RST     = 12'sh000;
	localparam int SHARP_SHIFT = 3;
	localparam int FIFO_DEPTH  = 16;
	localparam int LUT_DEPTH   = 1024;

	// register byte offsets
	localparam logic [7:0] OFS_SHARP      = 8'h00;
	localparam logic [7:0] OFS_FORMAT     = 8'h04;
	localparam logic [7:0] OFS_ROW_SEL    = 8'h08;
	localparam logic [7:0] OFS_COL_SEL    = 8'h0C;
	localparam logic [7:0] OFS_COEF       = 8'h10;
	localparam logic [7:0] OFS_LUT_EN     = 8'h14;
	localparam logic [7:0] OFS_LUT_INDEX  = 8'h18;
	localparam logic [7:0] OFS_LUT_VALUE  = 8'h1C;
	localparam logic [7:0] OFS_LUT_COMP   = 8'h20;
	localparam logic [7:0] OFS_STATUS     = 8'h24;

	// reset values and field limits
	localparam logic [2:0] SHARP_RST = 3'h0;
	localparam logic [2:0] SHARP_MAX = 3'h7;
	localparam logic [9:0] LUT_INDEX_RST = 10'h000;
	localparam logic       LUT_EN_RST = 1'b0;
	localparam logic [1:0] LUT_COMP_LUMA = 2'h0;

	// status bit positions
	localparam int ST_COLOR  = 0;
	localparam int ST_SHARP  = 1;
	localparam int ST_CCM    = 2;
	localparam int ST_LUT    = 3;
	localparam int ST_LVL_LO = 8;

	typedef enum logic [1:0] {
		COMP_R = 2'h0,
		COMP_G = 2'h1,
		COMP_B = 2'h2
	} cpp_comp_type;

	typedef enum logic [2:0] {
		FMT_MONO_8BIT       = 3'h0,
		FMT_RGB_8BIT        = 3'h1,
		FMT_YUV_411_8BIT    = 3'h2,
		FMT_YUV_422_8BIT    = 3'h3,
		FMT_RAW_10BIT       = 3'h4
	} cpp_format_type;

	localparam cpp_format_type FORMAT_RST = FMT_RGB_8BIT;

	// clamp a wide signed level into the pixel range
	function automatic logic [9:0] clampPix(input logic signed [31:0] v);
		if (v < 0) begin
			return 10'h000;
		end else if (v > 32'sd1023) begin
			return PIX_MAX;
		end else begin
			return v[9:0];
		end
	endfunction : clampPix

endpackage : cpp_pkg

// >>> logic/cpp_ccm_row.sv
// cpp_ccm_row: one output component of the colour correction matrix.
// assumes coefficients are signed fixed point with COEF_FB fraction bits.
`timescale 1ns/1ns
module cpp_ccm_row #(
	parameter int PW = cpp_pkg::PIX_W,
	parameter int CW = cpp_pkg::COEF_W,
	parameter int FB = cpp_pkg::COEF_FB
) (
	input  wire logic [PW-1:0]        ownPix,  // own component
	input  wire logic [PW-1:0]        pixA,    // first other component
	input  wire logic [PW-1:0]        pixB,    // second other component
	input  wire logic signed [CW-1:0] coefA,   // weight of pixA
	input  wire logic signed [CW-1:0] coefB,   // weight of pixB
	output logic [PW-1:0]             result   // corrected, clamped level
);
	logic signed [PW:0]      diffA;
	logic signed [PW:0]      diffB;
	logic signed [PW+CW:0]   prodA;
	logic signed [PW+CW:0]   prodB;
	logic signed [PW+CW+1:0] sum;
	logic signed [31:0]      acc;

	// own weight is one minus the others: own + a*(A-own) + b*(B-own)
	assign diffA = $signed({1'b0, pixA}) - $signed({1'b0, ownPix});
	assign diffB = $signed({1'b0, pixB}) - $signed({1'b0, ownPix});
	assign prodA = (PW+CW+1)'(diffA * coefA);
	assign prodB = (PW+CW+1)'(diffB * coefB);
	assign sum   = (PW+CW+2)'(prodA) + (PW+CW+2)'(prodB);
	assign acc   = 32'(sum >>> FB) + $signed(32'(ownPix));
	assign result = PW'(cpp_pkg::clampPix(acc));

endmodule : cpp_ccm_row

// >>> logic/cpp_fifo.sv
// cpp_fifo: synchronous valid/ready FIFO, width and depth as parameters.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module cpp_fifo #(
	parameter int WIDTH = 30,
	parameter int DEPTH = 16
) (
	input  wire logic                     clock,    // core clock
	input  wire logic                     rst,      // sync reset
	input  wire logic [WIDTH-1:0]         inData,   // write word
	input  wire logic                     inValid,  // write offered
	output logic                          inReady,  // space left
	output logic [WIDTH-1:0]              outData,  // head word
	output logic                          outValid, // not empty
	input  wire logic                     outReady, // reader takes head
	output logic [$clog2(DEPTH+1)-1:0]    level     // words held
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0]             wrPtr;
		logic [AW-1:0]             rdPtr;
		logic [$clog2(DEPTH+1)-1:0] count;
		logic                      notFull;
	} cpp_fifo_state_type;

	cpp_fifo_state_type state_reg;
	cpp_fifo_state_type state_next;
	logic [WIDTH-1:0]   mem [DEPTH];
	logic               doWrite;
	logic               doRead;

	assign inReady  = state_reg.notFull;
	assign outValid = (state_reg.count != '0);
	assign outData  = mem[state_reg.rdPtr];
	assign level    = state_reg.count;
	assign doWrite  = inValid & inReady;
	assign doRead   = outValid & outReady;

	always_comb begin
		state_next = state_reg;
		if (doWrite) begin
			state_next.wrPtr = (state_reg.wrPtr == AW'(DEPTH - 1)) ? '0 : state_reg.wrPtr + 1'b1;
		end
		if (doRead) begin
			state_next.rdPtr = (state_reg.rdPtr == AW'(DEPTH - 1)) ? '0 : state_reg.rdPtr + 1'b1;
		end
		if (doWrite && !doRead) begin
			state_next.count = state_reg.count + 1'b1;
		end else if (doRead && !doWrite) begin
			state_next.count = state_reg.count - 1'b1;
		end
		// space flag kept in a flop so ready leaves straight from a register
		state_next.notFull = (state_next.count != ($clog2(DEPTH+1))'(DEPTH));
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg         <= '0;
			state_reg.notFull <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clock) begin
		if (doWrite) begin
			mem[state_reg.wrPtr] <= inData;
		end
	end

endmodule : cpp_fifo

// >>> logic/cpp_post_process.sv
// cpp_post_process: pixel post-processing stage with Wishbone registers.
// assumes RGB pixels of 10 bits per component arrive in raster order on a
// valid/ready stream; the output stream honours back-pressure.
`timescale 1ns/1ns

// Notes on behaviour
// - sharpness strength 0..7, 0 off, default 0
// - larger strength gives stronger edge boost
// - sharpening only in RGB_8BIT_FORMAT, YUV411, YUV422 formats
// - mono variant has no sharpening or matrix
// - component = weighted RGB, own weight one-minus-others
// - row picks output, column picks input component
// - both matrix selectors reset to R
// - coefficient write hits selected element, -1..+1
// - diagonal fixed at one minus the others, reads back zero
// - matrix only in RGB_8BIT_FORMAT, YUV411, YUV422 formats
// - loadable 10-bit to 10-bit lookup table
// - table enable off passes, on maps all
// - index picks entry, value write stores it
// - index and value 0..1023, index default 0
// - read-only component selector reports luminance
module cpp_post_process #(
	parameter int  FIFO_DEPTH    = cpp_pkg::FIFO_DEPTH,
	parameter bit  COLOR_VARIANT = 1'b1
) (
	input  wire logic        clock,      // core clock, 250 MHz
	input  wire logic        rst,        // sync reset, active high
	input  wire logic        wb_cyc_i,   // bus cycle
	input  wire logic        wb_stb_i,   // bus strobe
	input  wire logic        wb_we_i,    // write enable
	input  wire logic [7:0]  wb_adr_i,   // byte address
	input  wire logic [3:0]  wb_sel_i,   // byte lanes
	input  wire logic [31:0] wb_dat_i,   // write data
	output logic [31:0]      wb_dat_o,   // read data
	output logic             wb_ack_o,   // acknowledge
	input  wire logic [9:0]  inRed,      // input red level
	input  wire logic [9:0]  inGreen,    // input green level
	input  wire logic [9:0]  inBlue,     // input blue level
	input  wire logic        inValid,    // input pixel offered
	output logic             inReady,    // input pixel taken
	output logic [9:0]       outRed,     // output red level
	output logic [9:0]       outGreen,   // output green level
	output logic [9:0]       outBlue,    // output blue level
	output logic             outValid,   // output pixel present
	input  wire logic        outReady    // downstream takes pixel
);
	localparam int PW = cpp_pkg::PIX_W;
	localparam int CW = cpp_pkg::COEF_W;
	localparam int LW = $clog2(FIFO_DEPTH + 1);

	typedef struct packed {
		logic [2:0]                   strength;
		cpp_pkg::cpp_format_type      format;
		cpp_pkg::cpp_comp_type        rowSel;
		cpp_pkg::cpp_comp_type        colSel;
		logic [5:0][CW-1:0]           coef;
		logic                         lutEn;
		logic [PW-1:0]                table_input_level;
		logic [3*PW-1:0]              prevPix;
		logic                         outValid;
		logic [3*PW-1:0]              outPix;
		logic                         ack;
		logic [31:0]                  rdata;
	} cpp_state_type;

	cpp_state_type state_reg;
	cpp_state_type state_next;
	// table contents survive reset; load before enabling
	logic [PW-1:0] lutMem [cpp_pkg::LUT_DEPTH];

	// six off-diagonal slots, row-major with the diagonal skipped
	function automatic logic [2:0] coefSlot(input logic [1:0] row, input logic [1:0] col);
		logic [1:0] c;
		c = (col > row) ? col - 2'h1 : col;
		return {row, 1'b0} + {2'h0, c[0]};
	endfunction : coefSlot

	// clamp a written coefficient into -1.0 .. +1.0
	function automatic logic [CW-1:0] coefLimit(input logic [31:0] d);
		logic signed [CW-1:0] v;
		v = $signed(d[CW-1:0]);
		if (v > cpp_pkg::COEF_ONE) begin
			return cpp_pkg::COEF_ONE;
		end else if (v < cpp_pkg::COEF_NEG_ONE) begin
			return cpp_pkg::COEF_NEG_ONE;
		end else begin
			return v;
		end
	endfunction : coefLimit

	// edge boost of one component against its left neighbour
	function automatic logic [PW-1:0] sharpen(input logic [PW-1:0] p,
			input logic [PW-1:0] prev, input logic [2:0] k);
		logic signed [PW:0]   d;
		logic signed [PW+4:0] prod;
		d = $signed({1'b0, p}) - $signed({1'b0, prev});
		// arithmetic shift floors negative boosts
		prod = (PW+5)'(d * $signed({1'b0, k}));
		return cpp_pkg::clampPix(32'(prod >>> cpp_pkg::SHARP_SHIFT) + $signed(32'(p)));
	endfunction : sharpen

	// formats that carry matrix and sharpening
	function automatic logic fmtAllows(input cpp_pkg::cpp_format_type f);
		return (f == cpp_pkg::FMT_RGB_8BIT) || (f == cpp_pkg::FMT_YUV_411_8BIT) ||
			(f == cpp_pkg::FMT_YUV_422_8BIT);
	endfunction : fmtAllows

	// input buffering
	logic [3*PW-1:0] fifoData;
	logic            fifoValid;
	logic            fifoTake;
	logic [LW-1:0]   fifoLevel;

	cpp_fifo #(
		.WIDTH (3 * PW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock    (clock),
		.rst      (rst),
		.inData   ({inRed, inGreen, inBlue}),
		.inValid  (inValid),
		.inReady  (inReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (fifoTake),
		.level    (fifoLevel)
	);

	logic [PW-1:0] pixR;
	logic [PW-1:0] pixG;
	logic [PW-1:0] pixB;
	assign pixR = fifoData[3*PW-1:2*PW];
	assign pixG = fifoData[2*PW-1:PW];
	assign pixB = fifoData[PW-1:0];

	logic ccmOn;
	logic sharpOn;
	assign ccmOn   = COLOR_VARIANT && fmtAllows(state_reg.format);
	assign sharpOn = ccmOn && (state_reg.strength != cpp_pkg::SHARP_RST);

	logic [PW-1:0] corrR;
	logic [PW-1:0] corrG;
	logic [PW-1:0] corrB;

	cpp_ccm_row u_row_r (
		.ownPix (pixR),
		.pixA   (pixG),
		.pixB   (pixB),
		.coefA  (state_reg.coef[0]),
		.coefB  (state_reg.coef[1]),
		.result (corrR)
	);

	cpp_ccm_row u_row_g (
		.ownPix (pixG),
		.pixA   (pixR),
		.pixB   (pixB),
		.coefA  (state_reg.coef[2]),
		.coefB  (state_reg.coef[3]),
		.result (corrG)
	);

	cpp_ccm_row u_row_b (
		.ownPix (pixB),
		.pixA   (pixR),
		.pixB   (pixG),
		.coefA  (state_reg.coef[4]),
		.coefB  (state_reg.coef[5]),
		.result (corrB)
	);

	logic [3*PW-1:0] stageCcm;
	logic [3*PW-1:0] stageSharp;
	logic [3*PW-1:0] stageLut;

	always_comb begin
		stageCcm = ccmOn ? {corrR, corrG, corrB} : fifoData;
		if (sharpOn) begin
			stageSharp[3*PW-1:2*PW] = sharpen(stageCcm[3*PW-1:2*PW],
				state_reg.prevPix[3*PW-1:2*PW], state_reg.strength);
			stageSharp[2*PW-1:PW]   = sharpen(stageCcm[2*PW-1:PW],
				state_reg.prevPix[2*PW-1:PW], state_reg.strength);
			stageSharp[PW-1:0]      = sharpen(stageCcm[PW-1:0],
				state_reg.prevPix[PW-1:0], state_reg.strength);
		end else begin
			stageSharp = stageCcm;
		end
		if (state_reg.lutEn) begin
			stageLut = {lutMem[stageSharp[3*PW-1:2*PW]],
				lutMem[stageSharp[2*PW-1:PW]],
				lutMem[stageSharp[PW-1:0]]};
		end else begin
			stageLut = stageSharp;
		end
	end

	// output register drains the buffer only when it can be replaced
	assign fifoTake = fifoValid && (!state_reg.outValid || outReady);

	// register bus decode
	logic        busReq;
	logic        busWrite;
	logic [2:0]  selSlot;
	logic        selDiag;
	logic        wrLutValue;
	assign busReq   = wb_cyc_i && wb_stb_i && !state_reg.ack;
	// writes land on the ack edge, once the master has seen the answer
	assign busWrite = wb_cyc_i && wb_stb_i && state_reg.ack && wb_we_i && wb_sel_i[0];
	assign selSlot  = coefSlot(state_reg.rowSel, state_reg.colSel);
	assign selDiag  = (state_reg.rowSel == state_reg.colSel);
	assign wrLutValue = busWrite && (wb_adr_i == cpp_pkg::OFS_LUT_VALUE);

	// unmapped offsets read zero
	logic [31:0] readValue;

	always_comb begin
		readValue = 32'h0000_0000;
		if (wb_adr_i == cpp_pkg::OFS_SHARP) begin
			readValue = {29'h0, state_reg.strength};
		end else if (wb_adr_i == cpp_pkg::OFS_FORMAT) begin
			readValue = {29'h0, state_reg.format};
		end else if (wb_adr_i == cpp_pkg::OFS_ROW_SEL) begin
			readValue = {30'h0, state_reg.rowSel};
		end else if (wb_adr_i == cpp_pkg::OFS_COL_SEL) begin
			readValue = {30'h0, state_reg.colSel};
		end else if (wb_adr_i == cpp_pkg::OFS_COEF) begin
			if (!selDiag) begin
				readValue = 32'($signed(state_reg.coef[selSlot]));
			end
		end else if (wb_adr_i == cpp_pkg::OFS_LUT_EN) begin
			readValue = {31'h0, state_reg.lutEn};
		end else if (wb_adr_i == cpp_pkg::OFS_LUT_INDEX) begin
			readValue = {22'h0, state_reg.table_input_level};
		end else if (wb_adr_i == cpp_pkg::OFS_LUT_VALUE) begin
			readValue = {22'h0, lutMem[state_reg.table_input_level]};
		end else if (wb_adr_i == cpp_pkg::OFS_LUT_COMP) begin
			readValue = {30'h0, cpp_pkg::LUT_COMP_LUMA};
		end else if (wb_adr_i == cpp_pkg::OFS_STATUS) begin
			readValue[cpp_pkg::ST_COLOR] = COLOR_VARIANT;
			readValue[cpp_pkg::ST_SHARP] = sharpOn;
			readValue[cpp_pkg::ST_CCM]   = ccmOn;
			readValue[cpp_pkg::ST_LUT]   = state_reg.lutEn;
			readValue[cpp_pkg::ST_LVL_LO +: LW] = fifoLevel;
		end
	end

	always_comb begin
		state_next = state_reg;
		// one-cycle ack: a held request is answered again every second cycle
		state_next.ack = busReq;
		if (busReq) begin
			state_next.rdata = readValue;
		end
		if (busWrite) begin
			if (wb_adr_i == cpp_pkg::OFS_SHARP) begin
				if (COLOR_VARIANT) begin
					state_next.strength = wb_dat_i[2:0];
				end
			end else if (wb_adr_i == cpp_pkg::OFS_FORMAT) begin
				if (wb_dat_i[2:0] <= cpp_pkg::FMT_RAW_10BIT) begin
					state_next.format = cpp_pkg::cpp_format_type'(wb_dat_i[2:0]);
				end
			end else if (wb_adr_i == cpp_pkg::OFS_ROW_SEL) begin
				if (wb_dat_i[1:0] <= cpp_pkg::COMP_B) begin
					state_next.rowSel = cpp_pkg::cpp_comp_type'(wb_dat_i[1:0]);
				end
			end else if (wb_adr_i == cpp_pkg::OFS_COL_SEL) begin
				if (wb_dat_i[1:0] <= cpp_pkg::COMP_B) begin
					state_next.colSel = cpp_pkg::cpp_comp_type'(wb_dat_i[1:0]);
				end
			end else if (wb_adr_i == cpp_pkg::OFS_COEF) begin
				if (COLOR_VARIANT && !selDiag) begin
					state_next.coef[selSlot] = coefLimit(wb_dat_i);
				end
			end else if (wb_adr_i == cpp_pkg::OFS_LUT_EN) begin
				state_next.lutEn = wb_dat_i[0];
			end else if (wb_adr_i == cpp_pkg::OFS_LUT_INDEX) begin
				state_next.table_input_level = wb_dat_i[PW-1:0];
			end
		end
		if (state_reg.outValid && outReady) begin
			state_next.outValid = 1'b0;
		end
		if (fifoTake) begin
			state_next.outValid = 1'b1;
			state_next.outPix   = stageLut;
			// sharpening compares against the corrected previous pixel
			state_next.prevPix  = stageCcm;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg          <= '0;
			state_reg.strength <= cpp_pkg::SHARP_RST;
			state_reg.format   <= cpp_pkg::FORMAT_RST;
			state_reg.rowSel   <= cpp_pkg::COMP_R;
			state_reg.colSel   <= cpp_pkg::COMP_R;
			state_reg.coef     <= {6{cpp_pkg::COEF_RST}};
			state_reg.lutEn    <= cpp_pkg::LUT_EN_RST;
			state_reg.table_input_level <= cpp_pkg::LUT_INDEX_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clock) begin
		if (wrLutValue) begin
			lutMem[state_reg.table_input_level] <= wb_dat_i[PW-1:0];
		end
	end

	assign wb_ack_o = state_reg.ack;
	assign wb_dat_o = state_reg.rdata;
	assign outValid = state_reg.outValid;
	assign outRed   = state_reg.outPix[3*PW-1:2*PW];
	assign outGreen = state_reg.outPix[2*PW-1:PW];
	assign outBlue  = state_reg.outPix[PW-1:0];

endmodule : cpp_post_process

// >>> sim/cpp_post_process_chk.sv
// cpp_post_process_chk: port assertions for the post-processing stage.
// assumes binding to cpp_post_process; sees its ports only.
`timescale 1ns/1ns
module cpp_post_process_chk (
	input wire logic        clock,    // core clock
	input wire logic        rst,      // sync reset
	input wire logic        wb_cyc_i, // bus cycle
	input wire logic        wb_stb_i, // bus strobe
	input wire logic        wb_we_i,  // write enable
	input wire logic [7:0]  wb_adr_i, // byte address
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic        wb_ack_o, // acknowledge
	input wire logic [9:0]  outRed,   // red out
	input wire logic [9:0]  outGreen, // green out
	input wire logic [9:0]  outBlue,  // blue out
	input wire logic        outValid, // pixel present
	input wire logic        outReady  // pixel taken
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	wire logic rdAck = wb_ack_o && !wb_we_i;
	AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_IDLE: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	AST_SHARP_RANGE: assert property (rdAck && wb_adr_i == 8'h00 |-> wb_dat_o < 32'h8)
		else $error("strength above seven");
	AST_SEL_RANGE: assert property (rdAck && wb_adr_i inside {8'h08, 8'h0C}
		|-> wb_dat_o < 32'h3)
		else $error("selector out of range");
	AST_COEF_RANGE: assert property (rdAck && wb_adr_i == 8'h10
		|-> $signed(wb_dat_o) >= -1024 && $signed(wb_dat_o) <= 1024)
		else $error("coefficient out of range");
	AST_LUT_RANGE: assert property (rdAck && wb_adr_i inside {8'h18, 8'h1C}
		|-> wb_dat_o[31:10] == 22'h0)
		else $error("table field above 1023");
	AST_COMP_LUMA: assert property (rdAck && wb_adr_i == 8'h20 |-> wb_dat_o == 32'h0)
		else $error("component report not luminance");
	AST_OUT_HOLD: assert property (outValid && !outReady
		|=> outValid && $stable({outRed, outGreen, outBlue}))
		else $error("pixel changed while stalled");
endmodule : cpp_post_process_chk

bind cpp_post_process cpp_post_process_chk chk (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .outRed(outRed), .outGreen(outGreen), .outBlue(outBlue),
	.outValid(outValid), .outReady(outReady));

// >>> sim/cpp_stream_sink.sv
// cpp_stream_sink: downstream image output with back-pressure.
// assumes the bench chooses hold or random stalls.
`timescale 1ns/1ns
module cpp_stream_sink (
	input  wire logic clock,   // core clock
	input  wire logic rst,     // sync reset
	input  wire logic hold,    // refuse all pixels
	input  wire logic jitter,  // random stalls
	output logic      outReady // accepts pixel
);
	initial outReady = 1'b0;
	always @(posedge clock) begin
		outReady <= !rst && !hold && (!jitter || $urandom_range(1) == 1);
	end
endmodule : cpp_stream_sink

// >>> sim/test_cpp_post_process.sv
// test_cpp_post_process: self-checking bench with a behavioural model.
// assumes cpp_post_process, cpp_fifo, cpp_ccm_row and the sink model.
`timescale 1ns/1ns
module test_cpp_post_process;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck;
	logic [3:0]  wbSel = 4'h0;
	logic [7:0]  wbAdr = 8'h00;
	logic [31:0] wbDat = 32'h0, wbDatO, rd;
	logic [9:0]  inRed = 10'h0, inGreen = 10'h0, inBlue = 10'h0, outRed, outGreen, outBlue;
	logic        inValid = 1'b0, inReady, outValid, outReady, hold = 1'b0, jitter = 1'b0;
	logic [29:0] expQ[$];
	int          miscompares = 0, comparisons = 0;
	int          coef[3][3], lut[1024], prev[3], k = 0, lutEn = 0, n;
	bit          on = 1'b0;
	logic [7:0]  rAdr[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h40};
	int          kTab[5] = '{0, 7, 3, 5, 1};
	int          enTab[5] = '{1, 0, 1, 1, 0};
	always #2 clock = ~clock;
	cpp_post_process uut (.clock(clock), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .inRed(inRed), .inGreen(inGreen),
		.inBlue(inBlue), .inValid(inValid), .inReady(inReady), .outRed(outRed),
		.outGreen(outGreen), .outBlue(outBlue), .outValid(outValid), .outReady(outReady));
	cpp_stream_sink sink (.clock(clock), .rst(rst), .hold(hold), .jitter(jitter),
		.outReady(outReady));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int w;
		w = 0;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbSel <= 4'hF;
		wbAdr <= adr;
		wbDat <= dat;
		do begin
			@(posedge clock);
			w++;
		end while (wbAck !== 1'b1 && w < 50);
		if (w >= 50) miscompares++;
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbSel <= 4'h0;
		@(posedge clock);
	endtask : wbXfer
	function automatic int clampI(input int v);
		return v < 0 ? 0 : (v > 1023 ? 1023 : v);
	endfunction : clampI
	task automatic pushPix(input int cnt);
		int p[3], m[3], o[3], s;
		for (int i = 0; i < cnt; i++) begin
			for (int c = 0; c < 3; c++) p[c] = $urandom_range(1023);
			for (int c = 0; c < 3; c++) begin
				s = 0;
				for (int j = 0; j < 3; j++) if (j != c) s += coef[c][j] * (p[j] - p[c]);
				m[c] = on ? clampI(p[c] + (s >>> 10)) : p[c];
			end
			for (int c = 0; c < 3; c++) begin
				o[c] = on ? clampI(m[c] + ((k * (m[c] - prev[c])) >>> 3)) : m[c];
				prev[c] = m[c];
				if (lutEn != 0) o[c] = lut[o[c]];
			end
			expQ.push_back({10'(o[0]), 10'(o[1]), 10'(o[2])});
			inRed <= 10'(p[0]);
			inGreen <= 10'(p[1]);
			inBlue <= 10'(p[2]);
			inValid <= 1'b1;
			do @(posedge clock); while (inReady !== 1'b1);
		end
		inValid <= 1'b0;
	endtask : pushPix
	task automatic drain();
		for (n = 0; n < 300 && expQ.size() > 0; n++) @(posedge clock);
		check(expQ.size(), 0, "pixels lost");
	endtask : drain
	always @(posedge clock) begin
		if (rst === 1'b0 && outValid === 1'b1 && outReady === 1'b1) begin
			if (expQ.size() == 0) check(1, 0, "extra pixel");
			else check({outRed, outGreen, outBlue}, expQ.pop_front(), "pixel");
		end
	end
	initial begin
		#(4 * 60000);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(97));
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		foreach (rAdr[i]) begin
			wbXfer(1'b0, rAdr[i], 32'h0);
			check(rd, rAdr[i] == 8'h04 ? 32'h1 : 32'h0, "reset value");
		end
		wbXfer(1'b1, 8'h08, 32'h3);
		wbXfer(1'b0, 8'h08, 32'h0);
		check(rd, 32'h0, "row select range");
		wbXfer(1'b1, 8'h04, 32'h7);
		wbXfer(1'b0, 8'h04, 32'h0);
		check(rd, 32'h1, "format code range");
		wbXfer(1'b1, 8'h10, 32'h123);
		wbXfer(1'b0, 8'h10, 32'h0);
		check(rd, 32'h0, "diagonal read");
		wbXfer(1'b1, 8'h0C, 32'h2);
		wbXfer(1'b1, 8'h10, 32'hFFFFF800);
		wbXfer(1'b0, 8'h10, 32'h0);
		check(rd, 32'hFFFFFC00, "coefficient clamp");
		wbXfer(1'b1, 8'h08, 32'h1);
		wbXfer(1'b0, 8'h10, 32'h0);
		check(rd, 32'h0, "other element kept");
		for (int i = 0; i < 1024; i++) begin
			lut[i] = $urandom_range(1023);
			wbXfer(1'b1, 8'h18, i);
			wbXfer(1'b1, 8'h1C, {22'h3FFFFF, 10'(lut[i])});
		end
		wbXfer(1'b1, 8'h18, 32'h3FF);
		wbXfer(1'b0, 8'h1C, 32'h0);
		check(rd, lut[1023], "table readback");
		$display("test registers done");
		for (int b = 0; b < 5; b++) begin
			rst <= 1'b1;
			repeat (2) @(posedge clock);
			rst <= 1'b0;
			@(posedge clock);
			k = kTab[b];
			lutEn = enTab[b];
			on = b >= 1 && b <= 3;
			prev = '{0, 0, 0};
			wbXfer(1'b1, 8'h04, b);
			wbXfer(1'b1, 8'h00, k);
			wbXfer(1'b1, 8'h14, lutEn);
			for (int r = 0; r < 3; r++) for (int c = 0; c < 3; c++) if (r != c) begin
				coef[r][c] = int'($urandom_range(2048)) - 1024;
				wbXfer(1'b1, 8'h08, r);
				wbXfer(1'b1, 8'h0C, c);
				wbXfer(1'b1, 8'h10, coef[r][c]);
			end
			wbXfer(1'b0, 8'h00, 32'h0);
			check(rd, k, "strength readback");
			wbXfer(1'b0, 8'h24, 32'h0);
			check(rd, {28'h0, lutEn[0], on, on && k != 0, 1'b1}, "status");
			jitter <= b[0];
			pushPix(24);
			drain();
			$display("test format %0d done", b);
		end
		hold <= 1'b1;
		fork
			pushPix(20);
		join_none
		repeat (40) @(posedge clock);
		check(inReady, 1'b0, "full fifo refuses");
		hold <= 1'b0;
		wait fork;
		drain();
		@(posedge clock);
		check(outValid, 1'b0, "empty after drain");
		$display("test buffering done");
		tally_and_finish();
	end
endmodule : test_cpp_post_process
